// >>> adpin_irq_pkg.sv
// Package: register map, field layout and types of the analog port pin interrupt block
`default_nettype none
package adpin_irq_pkg;
   localparam int          PIN_COUNT      = 6;
   localparam int          ADDR_W         = 4;
   localparam int          DATA_W         = 32;
   localparam logic [3:0]  OFF_ENABLE     = 4'h0;
   localparam logic [3:0]  OFF_FLAG       = 4'h4;
   localparam logic [3:0]  OFF_POLARITY   = 4'h8;
   localparam logic [3:0]  OFF_CONTROL    = 4'hc;
   localparam logic [3:0]  OFF_STATUS     = 4'h0;
   localparam logic [5:0]  ENABLE_RST     = 6'h00;
   localparam logic [5:0]  FLAG_RST       = 6'h00;
   localparam logic [5:0]  POLARITY_RST   = 6'h00;
   localparam logic [5:0]  ANALOG_SEL_RST = 6'h00;
   localparam logic [31:0] READ_ZERO      = 32'h0000_0000;
   // Control register layout: bits 5:0 analog select, bit 8 stop mode
   localparam int          CTL_ANALOG_LSB = 0;
   localparam int          CTL_STOP_BIT   = 8;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } bus_state_e;

   typedef struct packed {
      logic [3:0]  adr;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic        we;
      logic        cyc;
      logic        stb;
   } wb_req_s;

   typedef struct packed {
      bus_state_e  bus;
      logic [31:0] rdat;
      logic [5:0]  meta;
      logic [5:0]  sync;
      logic [5:0]  prev;
      logic [5:0]  enable;
      logic [5:0]  flag;
      logic [5:0]  polarity;
      logic [5:0]  analog_sel;
      logic        stop_mode;
      logic        irq;
      logic        wakeup;
      logic [5:0]  gpio_in;
   } state_s;
endpackage
`default_nettype wire

// >>> analog_port_pin_interrupt.sv
// Edge interrupt logic for a six-pin port shared with the analog converter
// Behaviour
// R01: Each of pins 5..0 has its own enable bit for its edge interrupt.
// R02: Edges are detected whatever the pin's direction or function.
// R03: A pin edge wakes the device from stop mode only when its enable bit is set.
// R04: Enable 1 passes the flag to the request, enable 0 masks it.
// R05: A flag sets on an active edge and reads 1 until cleared, 0 if no edge.
// R06: The active edge is rising or falling per the pin's polarity bit.
// R07: The interrupt request is high while any flag is set with its enable set.
// R08: Flags read at any time; writing 1 clears a flag, writing 0 leaves it.
// R09: Each pin serves as general I/O or as an analog converter input.
// R10: Pin levels pass a two-stage synchroniser before edge detection.
// R11: An edge in the cycle of a write-one clear keeps the flag set.
`default_nettype none
module analog_port_pin_interrupt #(
   parameter int PINS = adpin_irq_pkg::PIN_COUNT
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   input  wire logic                 i_wb_cyc,
   input  wire logic                 i_wb_stb,
   input  wire logic                 i_wb_we,
   input  wire logic [3:0]           i_wb_adr,
   input  wire logic [3:0]           i_wb_sel,
   input  wire logic [31:0]          i_wb_dat,
   output logic      [31:0]          o_wb_dat,
   output logic                      o_wb_ack,
   input  wire logic [5:0]           i_pin,
   output logic      [5:0]           o_pin_digital,
   output logic      [5:0]           o_analog_sel,
   output logic                      o_irq,
   output logic                      o_wakeup
);

   ////////////////////////////////////////////////////////////////////////////
   // Widths below are fixed at six bits, so any other count is refused
   if (PINS != adpin_irq_pkg::PIN_COUNT) begin : g_pins_bad
      $error("Pin count must be six");
   end

   adpin_irq_pkg::state_s  st_ff;
   adpin_irq_pkg::state_s  nxt_st;
   adpin_irq_pkg::wb_req_s req;

   assign req = '{adr: i_wb_adr, dat: i_wb_dat, sel: i_wb_sel, we: i_wb_we,
                  cyc: i_wb_cyc, stb: i_wb_stb};

   // Byte lane 0 carries all six pin bits
   function automatic logic [5:0] lane0(input logic [5:0] old, input logic [3:0] sel,
                                         input logic [31:0] dat);
      lane0 = sel[0] ? dat[5:0] : old;
   endfunction

   function automatic logic [31:0] widen(input logic [5:0] v);
      widen = {26'h000_0000, v};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [5:0] rise;
   logic [5:0] fall;
   logic [5:0] edge_hit;
   logic [5:0] clr;
   logic       access;

   always_comb begin
      nxt_st = st_ff;
      access = req.cyc && req.stb && (st_ff.bus == adpin_irq_pkg::BUS_IDLE);
      // Only the second stage feeds detection, avoiding metastable flags
      nxt_st.meta = i_pin;                                           // R10
      nxt_st.sync = st_ff.meta;                                      // R10
      nxt_st.prev = st_ff.sync;
      // Detection ignores direction and function select
      rise = st_ff.sync & ~st_ff.prev;                               // R02
      fall = ~st_ff.sync & st_ff.prev;
      edge_hit = (st_ff.polarity & rise) | (~st_ff.polarity & fall); // R06
      clr = 6'h00;
      nxt_st.rdat = adpin_irq_pkg::READ_ZERO;
      nxt_st.bus = adpin_irq_pkg::BUS_IDLE;
      if (access) begin
         nxt_st.bus = adpin_irq_pkg::BUS_ACK;
         if (req.we) begin
            unique case (req.adr)
               adpin_irq_pkg::OFF_ENABLE:
                  nxt_st.enable = lane0(st_ff.enable, req.sel, req.dat);   // R01
               adpin_irq_pkg::OFF_FLAG:
                  clr = req.sel[0] ? req.dat[5:0] : 6'h00;                 // R08
               adpin_irq_pkg::OFF_POLARITY:
                  nxt_st.polarity = lane0(st_ff.polarity, req.sel, req.dat);
               adpin_irq_pkg::OFF_CONTROL: begin
                  nxt_st.analog_sel = lane0(st_ff.analog_sel, req.sel, req.dat);
                  if (req.sel[1]) begin
                     nxt_st.stop_mode = req.dat[adpin_irq_pkg::CTL_STOP_BIT];
                  end
               end
               default: ;
            endcase
         end else begin
            unique case (req.adr)
               adpin_irq_pkg::OFF_ENABLE:   nxt_st.rdat = widen(st_ff.enable);
               adpin_irq_pkg::OFF_FLAG:     nxt_st.rdat = widen(st_ff.flag); // R08
               adpin_irq_pkg::OFF_POLARITY: nxt_st.rdat = widen(st_ff.polarity);
               adpin_irq_pkg::OFF_CONTROL:
                  nxt_st.rdat = widen(st_ff.analog_sel) |
                                {23'h00_0000, st_ff.stop_mode, 8'h00};
               default:                     nxt_st.rdat = adpin_irq_pkg::READ_ZERO;
            endcase
         end
      end
      // Set beats clear so no edge is lost
      nxt_st.flag = (st_ff.flag & ~clr) | edge_hit;                  // R05 R11
      nxt_st.irq = |(nxt_st.flag & st_ff.enable);                    // R04 R07
      // Only an enabled pin may restart the oscillator in stop
      nxt_st.wakeup = st_ff.stop_mode && |(edge_hit & st_ff.enable); // R03
      // Digital reading stays valid for pins lent to the converter
      nxt_st.gpio_in = st_ff.sync;                                   // R09
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= '{bus: adpin_irq_pkg::BUS_IDLE, rdat: adpin_irq_pkg::READ_ZERO,
                    meta: 6'h00, sync: 6'h00, prev: 6'h00,
                    enable: adpin_irq_pkg::ENABLE_RST, flag: adpin_irq_pkg::FLAG_RST,
                    polarity: adpin_irq_pkg::POLARITY_RST,
                    analog_sel: adpin_irq_pkg::ANALOG_SEL_RST, stop_mode: 1'b0,
                    irq: 1'b0, wakeup: 1'b0, gpio_in: 6'h00};
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign o_wb_dat      = st_ff.rdat;
   assign o_wb_ack      = st_ff.bus[0];                              // Ack code 2'b01, flop bit
   assign o_pin_digital = st_ff.gpio_in;
   assign o_analog_sel  = st_ff.analog_sel;                          // R09
   assign o_irq         = st_ff.irq;
   assign o_wakeup      = st_ff.wakeup;

endmodule
`default_nettype wire

// >>> apit_props.sv
// Checker: port-level properties of the pin interrupt block
`default_nettype none
module apit_props #(parameter int PINS = 6) (
   input wire logic        i_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_irq, o_wakeup,
   input wire logic [3:0]  i_wb_adr, i_wb_sel,
   input wire logic [31:0] i_wb_dat, o_wb_dat,
   input wire logic [5:0]  i_pin, o_pin_digital, o_analog_sel
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_ack; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
   a_ack: assert property (p_ack) else $error("bus not answered");
   property p_ack1; o_wb_ack |=> !o_wb_ack; endproperty
   a_ack1: assert property (p_ack1) else $error("ack too long");
   property p_rdz; !o_wb_ack |-> o_wb_dat == 32'h0000_0000; endproperty
   a_rdz: assert property (p_rdz) else $error("read data outside ack");
   // Guard covers the reset-held chain after release
   property p_dig; !$past(i_rst, 3) && !$past(i_rst, 2) && !$past(i_rst)
      |-> o_pin_digital == $past(i_pin, 3); endproperty
   a_dig: assert property (p_dig) else $error("pin level not three stages late");
   property p_wake; o_wakeup |-> o_irq; endproperty
   a_wake: assert property (p_wake) else $error("wakeup from masked pin");
   property p_asel; o_wb_ack && i_wb_we && i_wb_adr == adpin_irq_pkg::OFF_CONTROL && i_wb_sel[0]
      |=> o_analog_sel == $past(i_wb_dat[5:0]); endproperty
   a_asel: assert property (p_asel) else $error("analog select not stored");
   property p_mask; o_wb_ack && i_wb_we && i_wb_adr == adpin_irq_pkg::OFF_ENABLE && i_wb_sel[0]
      && i_wb_dat[5:0] == 6'h00 |=> !o_irq ##1 !o_irq; endproperty
   a_mask: assert property (p_mask) else $error("irq not masked");
   property p_irq; $rose(o_irq) |-> $past(i_pin, 2) != $past(i_pin, 3)
      || $past(i_pin, 3) != $past(i_pin, 4)
      || $past(o_wb_ack) || $past(o_wb_ack, 2) || $past(o_wb_ack, 3); endproperty
   a_irq: assert property (p_irq) else $error("irq without cause");
endmodule
bind analog_port_pin_interrupt apit_props #(.PINS(PINS)) u_props (.i_clk, .i_rst, .i_wb_cyc,
   .i_wb_stb, .i_wb_we, .o_wb_ack, .o_irq, .o_wakeup, .i_wb_adr, .i_wb_sel, .i_wb_dat,
   .o_wb_dat, .i_pin, .o_pin_digital, .o_analog_sel);
`default_nettype wire

// >>> pin_src.sv
// Partner: external source driving the port pins
`default_nettype none
module pin_src (
   input  wire logic       i_clk,
   input  wire logic [5:0] i_lvl,
   output var  logic [5:0] o_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Low from time zero so reset release shows no false edge
   initial o_pin = 6'h00;
   always @(posedge i_clk) o_pin <= i_lvl;
endmodule
`default_nettype wire

// >>> tb_analog_port_pin_interrupt.sv
// Testbench: register, edge, mask and wakeup scenarios for the pin interrupt block
`default_nettype none
module tb_analog_port_pin_interrupt;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk = 0, i_rst = 1, cyc = 0, stb = 0, we = 0, ack, irq, wake;
   logic [3:0]  adr = 4'h0, sel = 4'hf;
   logic [31:0] dat = 32'h0000_0000, rdat, expq[$];
   logic [5:0]  lvl = 6'h00, pin, dig, asel, pol, v;
   int          error_cnt = 0, n_tests = 0, seed = 62904, wk_cnt = 0;
   analog_port_pin_interrupt uut (.i_clk, .i_rst, .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_pin(pin), .o_pin_digital(dig), .o_analog_sel(asel), .o_irq(irq), .o_wakeup(wake));
   pin_src ps (.i_clk, .i_lvl(lvl), .o_pin(pin));
   //////////////////////////////////////////////////////////////////////////////////////////
   initial forever #10 i_clk = ~i_clk;
   always @(posedge i_clk) if (ack === 1'b1 && we === 1'b0) chk("rdata", expq.pop_front(), rdat);
   always @(negedge i_clk) if (wake === 1'b1) wk_cnt++;
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask
   // Held until ack is seen, then one idle cycle
   task automatic wb(input logic [3:0] a, input logic [31:0] d, input logic w,
                     input logic [3:0] s = 4'hf);
      @(posedge i_clk);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
      do @(posedge i_clk); while (ack !== 1'b1);
      {cyc, stb} <= 2'b00;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      expq.push_back(e);
      wb(a, 32'h0000_0000, 1'b0);
   endtask
   task automatic pins(input logic [5:0] l);
      @(posedge i_clk);
      lvl <= l;
      repeat (8) @(negedge i_clk);
   endtask
   task automatic close_out;
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int a = 0; a < 16; a += 2) rd(4'(a), 32'h0000_0000);
      v = 6'($random(seed)) | 6'h01;
      pol = 6'($random(seed)) | 6'h01;
      wb(adpin_irq_pkg::OFF_ENABLE, $random(seed) | 32'h0000_003f, 1'b1);
      rd(adpin_irq_pkg::OFF_ENABLE, 32'h0000_003f);
      wb(adpin_irq_pkg::OFF_ENABLE, 32'h0000_0000, 1'b1, 4'he);
      rd(adpin_irq_pkg::OFF_ENABLE, 32'h0000_003f);
      wb(adpin_irq_pkg::OFF_POLARITY, {26'h0, pol}, 1'b1);
      pins(v);
      rd(adpin_irq_pkg::OFF_FLAG, {26'h0, v & pol});
      chk("irq", 32'h0000_0001, {31'h0, irq});
      pins(6'h00);
      rd(adpin_irq_pkg::OFF_FLAG, {26'h0, v});
      wb(adpin_irq_pkg::OFF_FLAG, {26'h0, v & pol}, 1'b1);
      rd(adpin_irq_pkg::OFF_FLAG, {26'h0, v & ~pol});
      wb(adpin_irq_pkg::OFF_FLAG, 32'h0000_003f, 1'b1);
      rd(adpin_irq_pkg::OFF_FLAG, 32'h0000_0000);
      wb(adpin_irq_pkg::OFF_ENABLE, 32'h0000_0000, 1'b1);
      pins(v);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      wb(adpin_irq_pkg::OFF_ENABLE, 32'h0000_003f, 1'b1);
      repeat (3) @(negedge i_clk);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      wb(adpin_irq_pkg::OFF_POLARITY, 32'h0000_0000, 1'b1);
      wb(adpin_irq_pkg::OFF_CONTROL, {26'h4, pol}, 1'b1);
      chk("asel", {26'h0, pol}, {26'h0, asel});
      rd(adpin_irq_pkg::OFF_CONTROL, {26'h4, pol});
      pins(6'h00);
      chk("wake", 32'h0000_0001, wk_cnt);
      wb(adpin_irq_pkg::OFF_ENABLE, 32'h0000_0000, 1'b1);
      wb(adpin_irq_pkg::OFF_POLARITY, 32'h0000_003f, 1'b1);
      pins(v);
      chk("wake", 32'h0000_0001, wk_cnt);
      close_out();
   end
   initial begin
      repeat (4000) @(posedge i_clk);
      error_cnt++;
      close_out();
   end
endmodule
`default_nettype wire
